// File: simultaneous_sar_conversion_control_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module simultaneous_sar_conversion_control_tb_top;
   logic        clock_in = 1'b0;
   logic        sys_rst_in = 1'b1;
   logic        start = 1'b0;
   logic        comp = 1'b0;
   logic [11:0] span = 12'h000;
   logic [1:0]  lanes = 2'h0;
   logic        nap = 1'b0;
   logic        pd = 1'b0;
   logic        lvds = 1'b0;
   logic        lvp, lvn;
   logic        sclk;
   logic [3:0]  hold, sdata, conn;
   logic        busy, rdy, fact, napa, pda;
   logic [23:0] frame;
   logic [7:0]  nfr;
   int          miscompares = 0;
   int          checks_done = 0;

   always #2.5 clock_in = ~clock_in;

   ssc_sar_ctrl dut (
      .clock_in(clock_in), .sys_rst_in(sys_rst_in),
      .conversion_start_pin_in(start), .comparator_in(comp),
      .span_config_in(span), .lvds_mode_in(lvds),
      .lane_count_in(lanes), .serial_clock_in(sclk),
      .nap_in(nap), .power_down_in(pd),
      .hold_out(hold), .sample_clear_out(), .dac_connect_out(conn),
      .dac_code_out(), .busy_out(busy), .results_ready_out(rdy),
      .serial_data_out(sdata), .lvds_data_p_out(lvp),
      .lvds_data_n_out(lvn), .frame_active_out(fact),
      .nap_active_out(napa), .power_down_active_out(pda)
   );

   ssc_host_model host (
      .frame_active_in(fact), .serial_data_in(lvds ? {3'h0, lvp} : sdata),
      .lane_code_in(lanes), .serial_clock_out(sclk),
      .frame_out(frame), .frame_count_out(nfr)
   );

   task automatic check(input string what, input logic [23:0] exp,
                        input logic [23:0] got);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic give_verdict;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : give_verdict

   always @(negedge clock_in)
   begin
      if (!sys_rst_in && !$onehot0(conn))
         check("dac connect", 24'h0, {20'h0, conn});
      if (!sys_rst_in && lvn !== ~lvp)
         check("lvds pair", {23'h0, ~lvp}, {23'h0, lvn});
   end

   // A second start edge is raised mid-conversion and must change nothing.
   task automatic convert(input logic [11:0] sp, input logic c,
                          input logic [1:0] ln);
      logic [23:0] exp;
      logic [2:0]  s;
      logic [7:0]  n0;
      int          k;
      @(negedge clock_in);
      span = sp;
      comp = c;
      lanes = ln;
      n0 = nfr;
      start = 1'b1;
      k = 0;
      while (busy !== 1'b1 && k < 20)
      begin
         @(negedge clock_in);
         k++;
      end
      check("hold all", 24'hF, {20'h0, hold});
      start = 1'b0;
      repeat (6) @(negedge clock_in);
      start = 1'b1;
      repeat (6) @(negedge clock_in);
      start = 1'b0;
      k = 0;
      while (rdy !== 1'b1 && k < 2000)
      begin
         @(negedge clock_in);
         k++;
      end
      check("ready pulse", 24'h1, {23'h0, rdy});
      check("frames before ready", {16'h0, n0}, {16'h0, nfr});
      for (int ch = 0; ch < 4; ch++)
      begin
         s = sp[3 * ch +: 3];
         exp[5:0] = {3'(ch), s};
         exp[23:6] = (s == 3'h0 || !c) ? 18'h00000 : 18'h3FFFF;
         if (s[1])
            exp[23] = ~exp[23];
         k = 0;
         while (nfr !== n0 + 8'(ch + 1) && k < 1000)
         begin
            @(negedge clock_in);
            k++;
         end
         check("frame", exp, frame);
      end
      repeat (400) @(negedge clock_in);
      check("frame count", {16'h0, n0 + 8'h04}, {16'h0, nfr});
      check("busy after", 24'h0, {23'h0, busy});
      check("hold released", 24'h0, {20'h0, hold});
   endtask : convert

   task automatic idle_modes;
      @(negedge clock_in);
      nap = 1'b1;
      repeat (3) @(negedge clock_in);
      check("nap", 24'h1, {23'h0, napa});
      nap = 1'b0;
      pd = 1'b1;
      repeat (3) @(negedge clock_in);
      check("power down", 24'h1, {23'h0, pda});
      start = 1'b1;
      repeat (20) @(negedge clock_in);
      check("busy in power down", 24'h0, {23'h0, busy});
      start = 1'b0;
      pd = 1'b0;
   endtask : idle_modes

   initial
   begin
      repeat (8) @(negedge clock_in);
      sys_rst_in = 1'b0;
      repeat (4) @(negedge clock_in);
      convert(12'hA1F, 1'b1, 2'h0);
      convert(12'h2A6, 1'b0, 2'h3);
      convert(12'h58C, 1'b1, 2'h1);
      convert(12'hE4B, 1'b1, 2'h2);
      lvds = 1'b1;
      convert(12'h3D1, 1'b1, 2'h0);
      idle_modes;
      give_verdict;
   end

   initial
   begin
      #200000;
      miscompares++;
      give_verdict;
   end
endmodule : simultaneous_sar_conversion_control_tb_top
`default_nettype wire

// File: ssc_fifo2.sv
`timescale 1ns/10ps
`default_nettype none
module ssc_fifo2 #(
   parameter int WIDTH = ssc_pkg::FRAME_BITS,
   parameter int DEPTH = ssc_pkg::FIFO_DEPTH
) (
   input wire logic clock_in,
   input wire logic sys_rst_in,
   ssc_fifo_if.fifo port_if
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
   localparam logic [AW:0]   CNT_FULL = (AW + 1)'(DEPTH);
   localparam logic [AW:0]   CNT_ONE  = (AW + 1)'(1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [WIDTH-1:0] rd_data;
   logic             do_push;
   logic             do_pop;

   assign port_if.push_ready = (count != CNT_FULL);
   assign port_if.pop_valid  = (count != '0);
   assign port_if.pop_data   = rd_data;
   assign do_push = port_if.push_valid && port_if.push_ready;
   assign do_pop  = port_if.pop_valid && port_if.pop_ready;

   always_ff @(posedge clock_in)
   begin
      if (do_push)
      begin
         mem[wr_ptr] <= port_if.push_data;
      end
   end

   // Read data come from a register that follows the head entry.
   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         rd_data <= '0;
      end
      else if (do_pop || count == '0)
      begin
         if (do_push && (count == '0 || (count == CNT_ONE && do_pop)))
         begin
            rd_data <= port_if.push_data;
         end
         else
         begin
            rd_data <= mem[(rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1];
         end
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         if (do_push)
         begin
            wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
         end
         if (do_pop)
         begin
            rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
         end
         if (do_push && !do_pop)
         begin
            count <= count + CNT_ONE;
         end
         else if (do_pop && !do_push)
         begin
            count <= count - CNT_ONE;
         end
      end
   end

   property p_fifo_bound;
      @(posedge clock_in) disable iff (sys_rst_in)
      count <= CNT_FULL;
   endproperty
   a_fifo_bound: assert property (p_fifo_bound)
      else $error("fifo holds more words than its depth");

endmodule : ssc_fifo2
`default_nettype wire

// File: ssc_fifo_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ssc_fifo_if;
   logic                           push_valid;
   logic                           push_ready;
   logic [ssc_pkg::FRAME_BITS-1:0] push_data;
   logic                           pop_valid;
   logic                           pop_ready;
   logic [ssc_pkg::FRAME_BITS-1:0] pop_data;

   modport fifo (
      input  push_valid,
      input  push_data,
      input  pop_ready,
      output push_ready,
      output pop_valid,
      output pop_data
   );

   modport user (
      output push_valid,
      output push_data,
      output pop_ready,
      input  push_ready,
      input  pop_valid,
      input  pop_data
   );
endinterface : ssc_fifo_if
`default_nettype wire

// File: ssc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module ssc_host_model (
   input  wire logic        frame_active_in,
   input  wire logic [3:0]  serial_data_in,
   input  wire logic [1:0]  lane_code_in,
   output logic             serial_clock_out,
   output logic      [23:0] frame_out,
   output logic      [7:0]  frame_count_out
);
   logic [23:0] shift;
   int          lanes;

   // The link clock idles high and only runs while a frame is loaded.
   initial
   begin
      serial_clock_out = 1'b1;
      shift = 24'h000000;
      frame_out = 24'h000000;
      frame_count_out = 8'h00;
      forever
      begin
         wait (frame_active_in === 1'b1);
         lanes = int'(lane_code_in) + 1;
         for (int e = 0; e < 24 / lanes; e++)
         begin
            serial_clock_out = 1'b0;
            #32;
            for (int k = 0; k < lanes; k++)
               shift[23 - e * lanes - k] = serial_data_in[k];
            serial_clock_out = 1'b1;
            #32;
         end
         frame_out = shift;
         frame_count_out = frame_count_out + 8'h01;
         #32;
      end
   end
endmodule : ssc_host_model
`default_nettype wire

// File: ssc_pkg.sv
`default_nettype none
package ssc_pkg;

   localparam int NUM_CH         = 4;
   localparam int CH_SEL_BITS    = 2;
   localparam int RES_BITS       = 18;
   localparam int SPAN_BITS      = 3;
   localparam int SPAN_WORD_BITS = NUM_CH * SPAN_BITS;
   localparam int CH_ID_BITS     = 3;
   localparam int FRAME_BITS     = RES_BITS + CH_ID_BITS + SPAN_BITS;
   localparam int FRAME_CNT_BITS = 5;
   localparam int FIFO_DEPTH     = 2;
   localparam int BIT_IDX_BITS   = 5;
   localparam int LANE_CNT_BITS  = 3;
   localparam int LANE_CODE_BITS = 2;

   localparam logic [CH_SEL_BITS-1:0]    LAST_CH       = 2'h3;
   localparam logic [SPAN_BITS-1:0]      SPAN_DISABLED = 3'h0;
   localparam int                        SPAN_BIP_BIT  = 1;
   localparam logic [RES_BITS-1:0]       CODE_ZERO     = 18'h00000;
   localparam logic [RES_BITS-1:0]       CODE_MSB      = 18'h20000;
   localparam logic [BIT_IDX_BITS-1:0]   BIT_MSB       = 5'h11;
   localparam logic [BIT_IDX_BITS-1:0]   BIT_LSB       = 5'h00;
   localparam logic [LANE_CNT_BITS-1:0]  LANE_ONE      = 3'h1;
   localparam logic [FRAME_CNT_BITS-1:0] FRAME_LEN     = 5'h18;

   // Comparator and charge redistribution DAC settling time per trial bit.
   localparam int CLK_PERIOD_NS   = 5;
   localparam int SETTLE_NS       = 20;
   localparam int SETTLE_CYC      =
      (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_CNT_BITS = 3;
   localparam logic [SETTLE_CNT_BITS-1:0] SETTLE_LOAD =
      SETTLE_CNT_BITS'(SETTLE_CYC - 1);

   // Bit positions inside the pin synchroniser vector.
   localparam int SYNC_BITS  = 6;
   localparam int SI_START   = 0;
   localparam int SI_COMP    = 1;
   localparam int SI_SCLK    = 2;
   localparam int SI_LVDS    = 3;
   localparam int SI_LANE_LO = 4;

   typedef enum logic [6:0] {
      ST_IDLE   = 7'h01,
      ST_SELECT = 7'h02,
      ST_TRIAL  = 7'h04,
      ST_DECIDE = 7'h08,
      ST_STORE  = 7'h10,
      ST_NEXT   = 7'h20,
      ST_UNLOAD = 7'h40
   } ssc_state_t;

endpackage : ssc_pkg
`default_nettype wire

// File: ssc_placeholder_none.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// File: ssc_sar_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// RQ1: start edge holds all channels together
// RQ2: released channels track their input buffer
// RQ3: one held channel on the DAC
// RQ4: binary search from half to LSB
// RQ5: results leave only after all channels
// RQ6: each result spans eighteen bit codes
// RQ7: span per channel, latched each conversion
// RQ8: disabled channels skipped, result zero
// RQ9: bipolar two's complement, unipolar straight
// RQ10: codes 7,6,3,2 are bipolar spans
// RQ11: pin chooses CMOS lanes or LVDS
// RQ12: CMOS output uses one to four lanes
// RQ13: nap and power-down when idle
// RQ14: held sample cleared after its conversion
// RQ15: host packs four span codes, twelve bits
// RQ16: codes 5,4,1 are unipolar spans
// RQ17: start edges during conversion are ignored
module ssc_sar_ctrl (
   input  wire logic                                clock_in,
   input  wire logic                                sys_rst_in,
   input  wire logic                                conversion_start_pin_in,
   input  wire logic                                comparator_in,
   input  wire logic [ssc_pkg::SPAN_WORD_BITS-1:0]  span_config_in,
   input  wire logic                                lvds_mode_in,
   input  wire logic [ssc_pkg::LANE_CODE_BITS-1:0]  lane_count_in,
   input  wire logic                                serial_clock_in,
   input  wire logic                                nap_in,
   input  wire logic                                power_down_in,
   output logic      [ssc_pkg::NUM_CH-1:0]          hold_out,
   output logic      [ssc_pkg::NUM_CH-1:0]          sample_clear_out,
   output logic      [ssc_pkg::NUM_CH-1:0]          dac_connect_out,
   output logic      [ssc_pkg::RES_BITS-1:0]        dac_code_out,
   output logic                                     busy_out,
   output logic                                     results_ready_out,
   output logic      [ssc_pkg::NUM_CH-1:0]          serial_data_out,
   output logic                                     lvds_data_p_out,
   output logic                                     lvds_data_n_out,
   output logic                                     frame_active_out,
   output logic                                     nap_active_out,
   output logic                                     power_down_active_out
);
   ssc_pkg::ssc_state_t                     state;
   logic [ssc_pkg::SYNC_BITS-1:0]           sync1;
   logic [ssc_pkg::SYNC_BITS-1:0]           sync2;
   logic                                    start_prev;
   logic                                    sclk_prev;
   logic                                    start_edge;
   logic                                    sclk_fall;
   logic                                    accept;
   logic [ssc_pkg::CH_SEL_BITS-1:0]         ch;
   logic [ssc_pkg::BIT_IDX_BITS-1:0]        bit_idx;
   logic [ssc_pkg::SETTLE_CNT_BITS-1:0]     settle_cnt;
   logic [ssc_pkg::SPAN_BITS-1:0]           span_lat [ssc_pkg::NUM_CH];
   logic [ssc_pkg::SPAN_BITS-1:0]           next_span [ssc_pkg::NUM_CH];
   logic [ssc_pkg::RES_BITS-1:0]            result [ssc_pkg::NUM_CH];
   logic [ssc_pkg::RES_BITS-1:0]            next_result [ssc_pkg::NUM_CH];
   logic [ssc_pkg::NUM_CH-1:0]              next_hold;
   logic [ssc_pkg::NUM_CH-1:0]              next_clear;
   logic [ssc_pkg::SPAN_BITS-1:0]           cur_span;
   logic                                    cur_dis;
   logic                                    cur_bip;
   logic [ssc_pkg::RES_BITS-1:0]            formatted;
   logic [ssc_pkg::FRAME_BITS-1:0]          shift_reg;
   logic [ssc_pkg::FRAME_CNT_BITS-1:0]      bits_left;
   logic [ssc_pkg::LANE_CNT_BITS-1:0]       lanes_lat;
   logic                                    lvds_lat;
   logic                                    loaded;
   logic [ssc_pkg::NUM_CH-1:0]              next_lane;

   ssc_fifo_if fifo_bus ();

   ssc_fifo2 u_fifo (
      .clock_in   (clock_in),
      .sys_rst_in (sys_rst_in),
      .port_if    (fifo_bus.fifo)
   );

   // Pins from outside the clock domain pass two flip-flops first.
   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         sync1      <= '0;
         sync2      <= '0;
         start_prev <= 1'b0;
         sclk_prev  <= 1'b0;
      end
      else
      begin
         sync1      <= {lane_count_in, lvds_mode_in, serial_clock_in,
                        comparator_in, conversion_start_pin_in};
         sync2      <= sync1;
         start_prev <= sync2[ssc_pkg::SI_START];
         sclk_prev  <= sync2[ssc_pkg::SI_SCLK];
      end
   end

   assign start_edge = sync2[ssc_pkg::SI_START] && !start_prev;
   assign sclk_fall  = sclk_prev && !sync2[ssc_pkg::SI_SCLK];
   assign accept     = (state == ssc_pkg::ST_IDLE) && start_edge
                       && !power_down_active_out; // RQ17 RQ13

   assign cur_span = span_lat[ch];
   assign cur_dis  = (cur_span == ssc_pkg::SPAN_DISABLED); // RQ8
   assign cur_bip  = cur_span[ssc_pkg::SPAN_BIP_BIT]; // RQ10 RQ16
   // Bipolar codes flip the MSB of the offset-binary search result.
   assign formatted = cur_dis ? ssc_pkg::CODE_ZERO
                    : cur_bip ? {~dac_code_out[ssc_pkg::RES_BITS-1],
                                 dac_code_out[ssc_pkg::RES_BITS-2:0]} // RQ9
                    : dac_code_out; // RQ16

   generate
      for (genvar g = 0; g < ssc_pkg::NUM_CH; g++)
      begin : g_chan
         logic done_here;
         assign done_here = (ch == ssc_pkg::CH_SEL_BITS'(g))
                            && (((state == ssc_pkg::ST_SELECT) && cur_dis)
                                || (state == ssc_pkg::ST_STORE));
         // Each channel's span code comes from its own field.
         assign next_span[g] = accept
            ? span_config_in[g*ssc_pkg::SPAN_BITS +: ssc_pkg::SPAN_BITS]
            : span_lat[g]; // RQ7 RQ15
         assign next_hold[g] = accept ? 1'b1 // RQ1
                             : done_here ? 1'b0 // RQ2
                             : hold_out[g];
         assign next_clear[g]  = done_here; // RQ14
         assign next_result[g] = done_here ? formatted : result[g];
      end
   endgenerate

   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         hold_out         <= '0;
         sample_clear_out <= '0;
         for (int i = 0; i < ssc_pkg::NUM_CH; i++)
         begin
            span_lat[i] <= ssc_pkg::SPAN_DISABLED;
            result[i]   <= ssc_pkg::CODE_ZERO;
         end
      end
      else
      begin
         hold_out         <= next_hold;
         sample_clear_out <= next_clear;
         span_lat         <= next_span;
         result           <= next_result;
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         state <= ssc_pkg::ST_IDLE;
      end
      else
      begin
         case (state)
            ssc_pkg::ST_IDLE:
               if (accept)
               begin
                  state <= ssc_pkg::ST_SELECT;
               end
            ssc_pkg::ST_SELECT:
               state <= cur_dis ? ssc_pkg::ST_NEXT : ssc_pkg::ST_TRIAL;
            ssc_pkg::ST_TRIAL:
               if (settle_cnt == '0)
               begin
                  state <= ssc_pkg::ST_DECIDE;
               end
            ssc_pkg::ST_DECIDE:
               state <= (bit_idx == ssc_pkg::BIT_LSB)
                        ? ssc_pkg::ST_STORE : ssc_pkg::ST_TRIAL;
            ssc_pkg::ST_STORE:
               state <= ssc_pkg::ST_NEXT;
            ssc_pkg::ST_NEXT:
               state <= (ch == ssc_pkg::LAST_CH)
                        ? ssc_pkg::ST_UNLOAD : ssc_pkg::ST_SELECT; // RQ5
            ssc_pkg::ST_UNLOAD:
               if (fifo_bus.push_ready && ch == ssc_pkg::LAST_CH)
               begin
                  state <= ssc_pkg::ST_IDLE;
               end
            default:
               state <= ssc_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         ch <= '0;
      end
      else if (accept)
      begin
         ch <= '0;
      end
      else if ((state == ssc_pkg::ST_NEXT)
               || (state == ssc_pkg::ST_UNLOAD && fifo_bus.push_ready))
      begin
         ch <= ch + 1'b1; // RQ3
      end
   end

   // Successive approximation: one trial bit per settle window.
   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         dac_connect_out <= '0;
         dac_code_out    <= ssc_pkg::CODE_ZERO;
         bit_idx         <= ssc_pkg::BIT_MSB;
         settle_cnt      <= ssc_pkg::SETTLE_LOAD;
      end
      else
      begin
         case (state)
            ssc_pkg::ST_SELECT:
               if (!cur_dis)
               begin
                  dac_connect_out <= ssc_pkg::NUM_CH'(1) << ch; // RQ3
                  dac_code_out    <= ssc_pkg::CODE_MSB; // RQ4 RQ6
                  bit_idx         <= ssc_pkg::BIT_MSB;
                  settle_cnt      <= ssc_pkg::SETTLE_LOAD;
               end
            ssc_pkg::ST_TRIAL:
               if (settle_cnt != '0)
               begin
                  settle_cnt <= settle_cnt - 1'b1;
               end
            ssc_pkg::ST_DECIDE:
            begin
               dac_code_out[bit_idx] <= sync2[ssc_pkg::SI_COMP]; // RQ4
               if (bit_idx != ssc_pkg::BIT_LSB)
               begin
                  dac_code_out[bit_idx - 1'b1] <= 1'b1;
                  bit_idx    <= bit_idx - 1'b1;
                  settle_cnt <= ssc_pkg::SETTLE_LOAD;
               end
            end
            ssc_pkg::ST_STORE:
               dac_connect_out <= '0;
            default:
               dac_connect_out <= dac_connect_out;
         endcase
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         busy_out              <= 1'b0;
         results_ready_out     <= 1'b0;
         nap_active_out        <= 1'b0;
         power_down_active_out <= 1'b0;
      end
      else
      begin
         busy_out          <= (state != ssc_pkg::ST_IDLE) || accept;
         results_ready_out <= (state == ssc_pkg::ST_NEXT)
                              && (ch == ssc_pkg::LAST_CH); // RQ5
         nap_active_out    <= nap_in && (state == ssc_pkg::ST_IDLE)
                              && !accept; // RQ13
         power_down_active_out <= power_down_in
                                  && (state == ssc_pkg::ST_IDLE)
                                  && !accept; // RQ13
      end
   end

   assign fifo_bus.push_valid = (state == ssc_pkg::ST_UNLOAD); // RQ5
   assign fifo_bus.push_data  = {result[ch], ssc_pkg::CH_ID_BITS'(ch),
                                 span_lat[ch]};
   assign fifo_bus.pop_ready  = !loaded;

   generate
      for (genvar k = 0; k < ssc_pkg::NUM_CH; k++)
      begin : g_lane
         assign next_lane[k] = !lvds_lat
            && (ssc_pkg::LANE_CNT_BITS'(k) < lanes_lat)
            && shift_reg[ssc_pkg::FRAME_BITS-1-k]; // RQ12
      end
   endgenerate

   // Serial shifter; each falling serial clock edge moves one bit per lane.
   always_ff @(posedge clock_in)
   begin
      if (sys_rst_in)
      begin
         shift_reg        <= '0;
         bits_left        <= '0;
         lanes_lat        <= ssc_pkg::LANE_ONE;
         lvds_lat         <= 1'b0;
         loaded           <= 1'b0;
         serial_data_out  <= '0;
         lvds_data_p_out  <= 1'b0;
         lvds_data_n_out  <= 1'b1;
         frame_active_out <= 1'b0;
      end
      else
      begin
         frame_active_out <= loaded;
         if (fifo_bus.pop_valid && !loaded)
         begin
            shift_reg <= fifo_bus.pop_data;
            bits_left <= ssc_pkg::FRAME_LEN;
            loaded    <= 1'b1;
            lvds_lat  <= sync2[ssc_pkg::SI_LVDS]; // RQ11
            lanes_lat <= sync2[ssc_pkg::SI_LVDS] ? ssc_pkg::LANE_ONE
               : {1'b0, sync2[ssc_pkg::SI_LANE_LO +: 2]}
                 + ssc_pkg::LANE_ONE; // RQ12
         end
         else if (loaded && sclk_fall)
         begin
            serial_data_out <= next_lane;
            lvds_data_p_out <= lvds_lat && shift_reg[ssc_pkg::FRAME_BITS-1];
            lvds_data_n_out <= !(lvds_lat
                                 && shift_reg[ssc_pkg::FRAME_BITS-1]);
            shift_reg <= shift_reg << lanes_lat;
            bits_left <= bits_left - lanes_lat;
            if (bits_left == ssc_pkg::FRAME_CNT_BITS'(lanes_lat))
            begin
               loaded <= 1'b0;
            end
         end
      end
   end

   property p_hold_all;
      @(posedge clock_in) disable iff (sys_rst_in)
      accept |=> (hold_out == '1) ##1 (state == ssc_pkg::ST_TRIAL
                                      || state == ssc_pkg::ST_NEXT);
   endproperty
   a_hold_all: assert property (p_hold_all) // RQ1
      else $error("channels not held together on start");

   property p_one_channel;
      @(posedge clock_in) disable iff (sys_rst_in)
      $onehot0(dac_connect_out);
   endproperty
   a_one_channel: assert property (p_one_channel) // RQ3
      else $error("more than one channel on the DAC");

   property p_msb_trial;
      @(posedge clock_in) disable iff (sys_rst_in)
      (state == ssc_pkg::ST_SELECT && !cur_dis)
      |=> (dac_code_out == ssc_pkg::CODE_MSB) && $onehot(dac_connect_out);
   endproperty
   a_msb_trial: assert property (p_msb_trial) // RQ4
      else $error("search did not begin at half scale");

   property p_settle;
      @(posedge clock_in) disable iff (sys_rst_in)
      (state == ssc_pkg::ST_SELECT && !cur_dis)
      |=> (state == ssc_pkg::ST_TRIAL) [*4] ##1 (state == ssc_pkg::ST_DECIDE);
   endproperty
   a_settle: assert property (p_settle) // RQ4
      else $error("trial bit did not settle four cycles");

   property p_ready_after_all;
      @(posedge clock_in) disable iff (sys_rst_in)
      fifo_bus.push_valid |-> (hold_out == '0) && (dac_connect_out == '0);
   endproperty
   a_ready_after_all: assert property (p_ready_after_all) // RQ5
      else $error("result sent while a channel is still held");

   property p_skip_disabled;
      @(posedge clock_in) disable iff (sys_rst_in)
      (state == ssc_pkg::ST_SELECT && cur_dis)
      |=> (state == ssc_pkg::ST_NEXT) && (dac_connect_out == '0)
          && (result[$past(ch)] == ssc_pkg::CODE_ZERO);
   endproperty
   a_skip_disabled: assert property (p_skip_disabled) // RQ8
      else $error("disabled channel was converted");

   property p_bipolar_fmt;
      @(posedge clock_in) disable iff (sys_rst_in)
      (state == ssc_pkg::ST_STORE && cur_bip && !cur_dis)
      |=> result[$past(ch)][ssc_pkg::RES_BITS-1]
          == !$past(dac_code_out[ssc_pkg::RES_BITS-1]);
   endproperty
   a_bipolar_fmt: assert property (p_bipolar_fmt) // RQ9
      else $error("bipolar result not in two's complement");

   property p_clear;
      @(posedge clock_in) disable iff (sys_rst_in)
      (state == ssc_pkg::ST_STORE)
      |=> $onehot(sample_clear_out) && ((sample_clear_out & hold_out) == '0);
   endproperty
   a_clear: assert property (p_clear) // RQ14
      else $error("held sample not cleared after conversion");

   property p_ignore_busy;
      @(posedge clock_in) disable iff (sys_rst_in)
      (state != ssc_pkg::ST_IDLE && start_edge)
      |=> ($stable(ch) || $past(state) == ssc_pkg::ST_NEXT
           || $past(state) == ssc_pkg::ST_UNLOAD)
          && (state != ssc_pkg::ST_SELECT || $past(state) == ssc_pkg::ST_NEXT);
   endproperty
   a_ignore_busy: assert property (p_ignore_busy) // RQ17
      else $error("start edge restarted a running conversion");

endmodule : ssc_sar_ctrl
`default_nettype wire
